// ==== verilog/dcrc_cfg.svh ====
// Purpose: address map, field positions and reset values of the DMA CRC block
// Assumes: 32-bit Avalon-MM register words, byte addresses
// Notes:   definitions only
`ifndef DCRC_CFG_SVH
`define DCRC_CFG_SVH

// --------
// register byte offsets
// --------
`define DCRC_ADDR_W        8
`define DCRC_OFS_STATUS    8'h00
`define DCRC_OFS_LASTADDR  8'h04
`define DCRC_OFS_CTRL      8'h08
`define DCRC_OFS_SEED      8'h0C
`define DCRC_OFS_TAP       8'h10

// --------
// writable bits and reset values
// --------
`define DCRC_CTRL_WMASK    32'h39001FE7
`define DCRC_CTRL_RST      32'h00000000
`define DCRC_WORD_RST      32'h00000000
`define DCRC_ZERO16        16'h0000
`define DCRC_ONES32        32'hFFFFFFFF

// --------
// control field positions
// --------
`define DCRC_CRC_BYTE_ORDER_HI       29
`define DCRC_CRC_BYTE_ORDER_LO       28
`define DCRC_WBO_BIT       27
`define DCRC_CRC_REFLECT_BIT      24
`define DCRC_POLY_LEN_MINUS_ONE_HI       12
`define DCRC_POLY_LEN_MINUS_ONE_LO       8
`define DCRC_EN_BIT        7
`define DCRC_APP_BIT       6
`define DCRC_TYP_BIT       5
`define DCRC_CH_HI         2
`define DCRC_CH_LO         0

// --------
// byte order codes
// --------
`define DCRC_CRC_BYTE_ORDER_NONE     2'h0
`define DCRC_CRC_BYTE_ORDER_WORD     2'h1
`define DCRC_CRC_BYTE_ORDER_HALF     2'h2
`define DCRC_CRC_BYTE_ORDER_INHALF   2'h3

`endif

// ==== verilog/dcrc_pkg.sv ====
// Purpose: types shared by the DMA CRC block
// Assumes: nothing
// Notes:   carriers for bus observation, source beats and destination writes
package dcrc_pkg;

  // --------
  // carriers
  // --------
  typedef struct packed {
    logic        valid;
    logic        is_read;
    logic [2:0]  chan;
    logic [31:0] addr;
  } dcrc_acc_type;

  typedef struct packed {
    logic        valid;
    logic [2:0]  chan;
    logic        last;
    logic [31:0] data;
    logic [31:0] dst_start;
  } dcrc_beat_type;

  typedef struct packed {
    logic        valid;
    logic        is_crc;
    logic [31:0] addr;
    logic [31:0] data;
  } dcrc_dst_type;

  typedef struct packed {
    logic [1:0]  crc_byte_order;
    logic        reordered_write_back;
    logic        crc_reflect;
    logic [4:0]  poly_len_minus_one;
    logic        en;
    logic        app;
    logic        typ;
    logic [2:0]  ch;
  } dcrc_ctrl_type;

  // --------
  // append sequencer states
  // --------
  typedef enum logic [1:0] {
    DCRC_ST_RUN    = 2'b01,
    DCRC_ST_APPEND = 2'b10
  } dcrc_state_type;

endpackage

// ==== verilog/dcrc_top.sv ====
// Purpose: DMA CRC/checksum unit with bus status and last-address capture
// Assumes: one 32-bit source word per beat, whole word folded in one cycle
// Notes:   registers over Avalon-MM with waitrequest, two-cycle access
//
// How it works
// [RULE_01] status read flag is 1 after a DMA read, 0 after a write
// [RULE_02] status channel field holds the most recently active DMA channel
// [RULE_03] last-address register captures the address of every DMA access
// [RULE_04] byte-order field reorders source data before the CRC
// [RULE_05] write-order bit sends reordered data to destination, else unaltered
// [RULE_06] reflect bit feeds LFSR least significant bit first
// [RULE_07] reflect bit also selects reflected IP header checksum
// [RULE_08] polynomial length field is length minus one; ignored in IP mode
// [RULE_09] enable bit routes the selected channel's transfers through the CRC
// [RULE_10] append mode drops destination data and writes CRC at block end
// [RULE_11] without append, data goes to CRC and to destination
// [RULE_12] type bit selects IP header checksum or LFSR CRC
// [RULE_13] channel-select field attaches the CRC to channels 0 to 7
// [RULE_14] append mode cannot be set while write-order bit is 1
// [RULE_15] unimplemented status and control bits read zero, writes ignored
// [RULE_16] writing data register seeds the CRC; read masks above length
// [RULE_17] IP mode keeps sixteen bits, complemented on write and read
// [RULE_18] each tap bit enables feedback XOR into its stage
// [RULE_19] one LFSR step per data bit, feedback from top active stage
// [RULE_20] status and address capture clear at reset, ignore writes
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`include "dcrc_cfg.svh"

module dcrc_top
  import dcrc_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    rstn_i,
  // avalon-mm register slave
  input  wire logic [`DCRC_ADDR_W-1:0] avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  output logic      [31:0]             avs_readdata_o,
  output logic                         avs_waitrequest_o,
  // dma bus observation
  input  wire dcrc_acc_type            dma_acc_i,
  // channel source beats
  input  wire dcrc_beat_type           src_beat_i,
  output logic                         src_ready_o,
  // destination writes
  output dcrc_dst_type                 dst_o
);

  // --------------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------------
  logic        rst_meta_r;
  logic        rst_n_r;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // --------------------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------------------
  function automatic logic [31:0] reorder(input logic [31:0] d, input logic [1:0] mode);
    logic [31:0] r;
    r = d;
    case (mode)
      `DCRC_CRC_BYTE_ORDER_WORD:   r = {d[7:0], d[15:8], d[23:16], d[31:24]};
      `DCRC_CRC_BYTE_ORDER_HALF:   r = {d[15:0], d[31:16]};
      `DCRC_CRC_BYTE_ORDER_INHALF: r = {d[23:16], d[31:24], d[7:0], d[15:8]};
      default:           r = d;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] len_mask(input logic [4:0] poly_len_minus_one);
    return `DCRC_ONES32 >> (5'd31 - poly_len_minus_one);
  endfunction

  function automatic logic [31:0] lfsr_word(input logic [31:0] crc, input logic [31:0] data,
                                            input logic [31:0] tap, input logic [4:0] poly_len_minus_one,
                                            input logic refl);
    logic [31:0] c;
    logic [31:0] m;
    logic        b;
    logic        fb;
    c  = crc;
    m  = len_mask(poly_len_minus_one);
    b  = 1'b0;
    fb = 1'b0;
    for (int i = 0; i < 32; i++) begin
      b  = refl ? data[i] : data[31-i];                        // [RULE_06]
      fb = c[poly_len_minus_one] ^ b;                                        // [RULE_19]
      c  = ((c << 1) ^ (tap & {32{fb}})) & m;                  // [RULE_18]
    end
    return c;
  endfunction

  function automatic logic [15:0] rev16(input logic [15:0] h);
    logic [15:0] r;
    r = h;
    for (int i = 0; i < 16; i++) begin
      r[i] = h[15-i];
    end
    return r;
  endfunction

  function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

  function automatic logic [15:0] ip_word(input logic [15:0] sum, input logic [31:0] data,
                                          input logic refl);
    logic [15:0] hi;
    logic [15:0] lo;
    hi = refl ? rev16(data[31:16]) : data[31:16];              // [RULE_07]
    lo = refl ? rev16(data[15:0]) : data[15:0];
    return oc_add(oc_add(sum, hi), lo);
  endfunction

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic            ack_r;
  logic [31:0]     rdata_r;
  logic            last_access_was_read_r;
  logic [2:0]      last_active_channel_r;
  logic [31:0]     dma_last_access_address_r;
  logic [31:0]     crc_control_r;
  logic [31:0]     crc_seed_result_r;
  logic [31:0]     crc_seed_result_nxt;
  logic [31:0]     crc_tap_enable_r;
  dcrc_state_type  state_r;
  dcrc_state_type  state_nxt;
  logic [31:0]     app_addr_r;
  dcrc_dst_type    dst_r;
  dcrc_dst_type    dst_nxt;

  // --------------------------------------------------------------------------
  // control field decode
  // --------------------------------------------------------------------------
  dcrc_ctrl_type   ctrl;

  assign ctrl.crc_byte_order = crc_control_r[`DCRC_CRC_BYTE_ORDER_HI:`DCRC_CRC_BYTE_ORDER_LO];
  assign ctrl.reordered_write_back  = crc_control_r[`DCRC_WBO_BIT];
  assign ctrl.crc_reflect = crc_control_r[`DCRC_CRC_REFLECT_BIT];
  assign ctrl.poly_len_minus_one = crc_control_r[`DCRC_POLY_LEN_MINUS_ONE_HI:`DCRC_POLY_LEN_MINUS_ONE_LO];
  assign ctrl.en   = crc_control_r[`DCRC_EN_BIT];
  assign ctrl.app  = crc_control_r[`DCRC_APP_BIT];
  assign ctrl.typ  = crc_control_r[`DCRC_TYP_BIT];
  assign ctrl.ch   = crc_control_r[`DCRC_CH_HI:`DCRC_CH_LO];

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  wire logic        bus_req    = avs_read_i | avs_write_i;
  wire logic        bus_done   = bus_req & ack_r;
  wire logic        wr_done    = avs_write_i & ack_r;
  wire logic        sel_status = (avs_address_i == `DCRC_OFS_STATUS);
  wire logic        sel_laddr  = (avs_address_i == `DCRC_OFS_LASTADDR);
  wire logic        sel_ctrl   = (avs_address_i == `DCRC_OFS_CTRL);
  wire logic        sel_seed   = (avs_address_i == `DCRC_OFS_SEED);
  wire logic        sel_tap    = (avs_address_i == `DCRC_OFS_TAP);
  wire logic [31:0] be_mask    = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  assign avs_waitrequest_o = bus_req & ~ack_r;
  assign avs_readdata_o    = rdata_r;

  // --------------------------------------------------------------------------
  // control write: append refused while write-order is set
  // --------------------------------------------------------------------------
  wire logic [31:0] ctrl_merge = ((crc_control_r & ~be_mask) | (avs_writedata_i & be_mask))
                                 & `DCRC_CTRL_WMASK;                              // [RULE_15]
  wire logic [31:0] ctrl_wr    = ctrl_merge[`DCRC_WBO_BIT]
                                 ? (ctrl_merge & ~(32'h00000001 << `DCRC_APP_BIT))  // [RULE_14]
                                 : ctrl_merge;

  // --------------------------------------------------------------------------
  // crc value as software sees it
  // --------------------------------------------------------------------------
  wire logic [31:0] poly_mask  = len_mask(ctrl.poly_len_minus_one);                              // [RULE_08]
  wire logic [31:0] crc_view   = ctrl.typ ? {`DCRC_ZERO16, ~crc_seed_result_r[15:0]}  // [RULE_17]
                                          : (crc_seed_result_r & poly_mask);        // [RULE_16]
  wire logic [31:0] seed_merge = (crc_view & ~be_mask) | (avs_writedata_i & be_mask);
  wire logic [31:0] seed_wr    = ctrl.typ ? {`DCRC_ZERO16, ~seed_merge[15:0]}       // [RULE_17]
                                          : (seed_merge & poly_mask);               // [RULE_16]
  wire logic [31:0] tap_wr     = (crc_tap_enable_r & ~be_mask) | (avs_writedata_i & be_mask);

  wire logic [31:0] status_view = {28'h0000000, last_access_was_read_r,
                                   last_active_channel_r};                        // [RULE_15]
  wire logic [31:0] rd_mux = sel_status ? status_view :
                             sel_laddr  ? dma_last_access_address_r :
                             sel_ctrl   ? crc_control_r :
                             sel_seed   ? crc_view :
                             sel_tap    ? crc_tap_enable_r : `DCRC_WORD_RST;

  // --------------------------------------------------------------------------
  // datapath
  // --------------------------------------------------------------------------
  wire logic        in_run   = (state_r == DCRC_ST_RUN);
  wire logic        beat_ok  = src_beat_i.valid & in_run;
  wire logic        crc_hit  = beat_ok & ctrl.en & (src_beat_i.chan == ctrl.ch);  // [RULE_09] [RULE_13]
  wire logic [31:0] ord_data = reorder(src_beat_i.data, ctrl.crc_byte_order);               // [RULE_04]
  wire logic [31:0] lfsr_nxt = lfsr_word(crc_seed_result_r, ord_data, crc_tap_enable_r,
                                         ctrl.poly_len_minus_one, ctrl.crc_reflect);
  wire logic [31:0] ip_nxt   = {`DCRC_ZERO16, ip_word(crc_seed_result_r[15:0], ord_data, ctrl.crc_reflect)};
  wire logic [31:0] fold_nxt = ctrl.typ ? ip_nxt : lfsr_nxt;                      // [RULE_12]
  wire logic        app_end  = crc_hit & ctrl.app & src_beat_i.last;              // [RULE_10]

  assign src_ready_o = in_run;
  assign dst_o       = dst_r;

  always_comb begin
    crc_seed_result_nxt = crc_seed_result_r;
    if (wr_done && sel_seed) begin
      crc_seed_result_nxt = seed_wr;                                             // [RULE_16]
    end else if (crc_hit) begin
      crc_seed_result_nxt = fold_nxt;                                            // [RULE_19]
    end
  end

  always_comb begin
    state_nxt = state_r;
    dst_nxt   = '0;
    case (state_r)
      DCRC_ST_RUN: begin
        if (app_end) begin
          state_nxt = DCRC_ST_APPEND;
        end
        if (beat_ok && !(crc_hit && ctrl.app)) begin                             // [RULE_10]
          dst_nxt.valid = 1'b1;
          dst_nxt.data  = (crc_hit && ctrl.reordered_write_back) ? ord_data : src_beat_i.data;    // [RULE_05] [RULE_11]
        end
      end
      DCRC_ST_APPEND: begin
        state_nxt      = DCRC_ST_RUN;
        dst_nxt.valid  = 1'b1;
        dst_nxt.is_crc = 1'b1;
        dst_nxt.addr   = app_addr_r;                                             // [RULE_10]
        dst_nxt.data   = crc_view;
      end
      default: begin
        state_nxt = DCRC_ST_RUN;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // bus handshake and read data
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r   <= 1'b0;
      rdata_r <= `DCRC_WORD_RST;
    end else begin
      ack_r   <= bus_req & ~ack_r;
      rdata_r <= (avs_read_i && !ack_r) ? rd_mux : rdata_r;
    end
  end

  // --------------------------------------------------------------------------
  // dma bus status capture
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      last_access_was_read_r    <= 1'b0;                                         // [RULE_20]
      last_active_channel_r     <= 3'h0;
      dma_last_access_address_r <= `DCRC_WORD_RST;
    end else if (dma_acc_i.valid) begin
      last_access_was_read_r    <= dma_acc_i.is_read;                            // [RULE_01]
      last_active_channel_r     <= dma_acc_i.chan;                               // [RULE_02]
      dma_last_access_address_r <= dma_acc_i.addr;                               // [RULE_03]
    end
  end

  // --------------------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      crc_control_r    <= `DCRC_CTRL_RST;
      crc_tap_enable_r <= `DCRC_WORD_RST;
    end else begin
      crc_control_r    <= (wr_done && sel_ctrl) ? ctrl_wr : crc_control_r;
      crc_tap_enable_r <= (wr_done && sel_tap) ? tap_wr : crc_tap_enable_r;
    end
  end

  // --------------------------------------------------------------------------
  // crc state
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      crc_seed_result_r <= `DCRC_WORD_RST;
    end else begin
      crc_seed_result_r <= crc_seed_result_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // append sequencer and destination port
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r    <= DCRC_ST_RUN;
      app_addr_r <= `DCRC_WORD_RST;
      dst_r      <= '0;
    end else begin
      state_r    <= state_nxt;
      app_addr_r <= app_end ? src_beat_i.dst_start : app_addr_r;
      dst_r      <= dst_nxt;
    end
  end

endmodule

// ==== tb/dcrc_top_chk.sv ====
// Purpose: port-level checks of the DMA CRC block
// Assumes: control shadow follows byte-enabled Avalon writes, one request at a time
// Notes:   bound from the testbench top file
`timescale 1ns/1ns
`include "dcrc_cfg.svh"

module dcrc_top_chk
  import dcrc_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    rstn_i,
  // register bus
  input  wire logic [`DCRC_ADDR_W-1:0] avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  input  wire logic [31:0]             avs_readdata_o,
  input  wire logic                    avs_waitrequest_o,
  // datapath
  input  wire dcrc_acc_type            dma_acc_i,
  input  wire dcrc_beat_type           src_beat_i,
  input  wire logic                    src_ready_o,
  input  wire dcrc_dst_type            dst_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  logic [31:0]   ctl_r;
  logic [31:0]   addr_r;
  logic [3:0]    st_r;
  dcrc_ctrl_type sc;
  wire        rd_done = avs_read_i & ~avs_waitrequest_o;
  wire        wr_ctl  = avs_write_i & ~avs_waitrequest_o & (avs_address_i == `DCRC_OFS_CTRL);
  wire [31:0] be_m    = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                         {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] wv      = ((ctl_r & ~be_m) | (avs_writedata_i & be_m)) & `DCRC_CTRL_WMASK;
  wire [31:0] ctl_nxt = wv[27] ? (wv & 32'hFFFFFFBF) : wv;
  wire        take    = src_beat_i.valid & src_ready_o;
  wire        hit     = take & sc.en & (src_beat_i.chan == sc.ch);
  assign sc = {ctl_r[29:27], ctl_r[24], ctl_r[12:5], ctl_r[2:0]};

  function automatic logic [31:0] reo(input logic [31:0] x, input logic [1:0] b);
    case (b)
      2'h1: reo = {x[7:0], x[15:8], x[23:16], x[31:24]};
      2'h2: reo = {x[15:0], x[31:16]};
      2'h3: reo = {x[23:16], x[31:24], x[7:0], x[15:8]};
      default: reo = x;
    endcase
  endfunction

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctl_r  <= 32'h00000000;
      addr_r <= 32'h00000000;
      st_r   <= 4'h0;
    end else begin
      if (wr_ctl) ctl_r <= ctl_nxt;
      if (dma_acc_i.valid) st_r <= {dma_acc_i.is_read, dma_acc_i.chan};
      if (dma_acc_i.valid) addr_r <= dma_acc_i.addr;
    end
  end

  // --------
  // assertions
  // --------
  AST_STATUS_RD: assert property (
    rd_done && avs_address_i == `DCRC_OFS_STATUS |-> avs_readdata_o == {28'h0000000, st_r})
    else $error("status read differs from last bus access");
  AST_ADDR_RD: assert property (
    rd_done && avs_address_i == `DCRC_OFS_LASTADDR |-> avs_readdata_o == addr_r)
    else $error("last address read differs");
  AST_CTRL_RD: assert property (
    rd_done && avs_address_i == `DCRC_OFS_CTRL |-> avs_readdata_o == ctl_r)
    else $error("control read differs from writes");
  AST_UNMAPPED: assert property (
    rd_done && avs_address_i > `DCRC_OFS_TAP |-> avs_readdata_o == 32'h00000000)
    else $error("unmapped read not zero");
  AST_PASS: assert property (
    take && !(hit && (sc.reordered_write_back || sc.app)) |=> dst_o.valid && !dst_o.is_crc && dst_o.data == $past(src_beat_i.data))
    else $error("destination data altered");
  AST_WBO: assert property (
    hit && sc.reordered_write_back |=> dst_o.valid && dst_o.data == reo($past(src_beat_i.data), $past(ctl_r[29:28])))
    else $error("reordered write-back wrong");
  AST_APP_DROP: assert property (
    hit && sc.app && !src_beat_i.last |=> !dst_o.valid)
    else $error("append mode wrote source data");
  AST_APP_CRC: assert property (
    hit && sc.app && src_beat_i.last |=> !src_ready_o ##1
      (dst_o.valid && dst_o.is_crc && dst_o.addr == $past(src_beat_i.dst_start, 2)))
    else $error("append result not written to start address");
  AST_READY_ONE: assert property (
    !src_ready_o |=> src_ready_o)
    else $error("source stalled beyond one cycle");

  C_APPEND: cover property (hit && sc.app && src_beat_i.last);
  C_WBO:    cover property (hit && sc.reordered_write_back);
  C_SEED:   cover property (rd_done && avs_address_i == `DCRC_OFS_SEED);
endmodule

// ==== tb/dcrc_dma_model.sv ====
// Purpose: channel datapath model that feeds bus accesses and source beats
// Assumes: beats held until taken, released lines show inverted data
// Notes:   hold keeps valid high so the next beat follows back to back
`timescale 1ns/1ns

module dcrc_dma_model
  import dcrc_pkg::*;
(
  // clock
  input  wire logic   sys_clk_i,
  // flow control
  input  wire logic   src_ready_i,
  // driven structs
  output dcrc_acc_type  dma_acc_o,
  output dcrc_beat_type src_beat_o
);
  bit held = 1'b0;

  initial begin
    dma_acc_o  = '0;
    src_beat_o = '0;
  end

  task automatic access(input logic rd, input logic [2:0] ch, input logic [31:0] a);
    dcrc_acc_type t;
    @(posedge sys_clk_i);
    dma_acc_o <= {1'b1, rd, ch, a};
    @(posedge sys_clk_i);
    t = ~dma_acc_o;
    t.valid = 1'b0;
    dma_acc_o <= t;
  endtask

  task automatic beat(input logic [2:0] ch, input logic last, input logic [31:0] d,
                      input logic [31:0] ds, input logic hold);
    dcrc_beat_type t;
    if (!held) @(posedge sys_clk_i);
    held = hold;
    src_beat_o <= {1'b1, ch, last, d, ds};
    do @(posedge sys_clk_i); while (src_ready_i !== 1'b1);
    t = ~src_beat_o;
    t.valid = 1'b0;
    if (!hold) src_beat_o <= t;
  endtask
endmodule

// ==== tb/dcrc_top_tb.sv ====
// Purpose: self-checking bench of the DMA CRC block
// Assumes: checker bound below, channel model drives the datapath
// Notes:   random modes and data, register corners, append sequence
`timescale 1ns/1ns
`include "dcrc_cfg.svh"

module dcrc_top_tb
  import dcrc_pkg::*;
;
  logic          sys_clk_i = 1'b0;
  logic          rstn_i = 1'b0;
  logic [7:0]    avs_address_i = 8'h00;
  logic          avs_read_i = 1'b0;
  logic          avs_write_i = 1'b0;
  logic [31:0]   avs_writedata_i = 32'h00000000;
  logic [3:0]    avs_byteenable_i = 4'hF;
  logic [31:0]   avs_readdata_o;
  logic          avs_waitrequest_o;
  logic          src_ready_o;
  dcrc_acc_type  dma_acc_i;
  dcrc_beat_type src_beat_i;
  dcrc_dst_type  dst_o;
  int            n_mismatch = 0;
  int            check_count = 0;
  int            seed = 43;
  logic [31:0]   m_crc, q, tap, sd, ctl, d;
  logic [31:0]   cap_d = 32'h00000000;
  logic [31:0]   cap_a = 32'h00000000;
  logic [15:0]   m_ip;

  always #25 sys_clk_i = ~sys_clk_i;

  dcrc_top dcrc_top_inst (.*);
  dcrc_dma_model dcrc_dma_model_inst (.sys_clk_i(sys_clk_i), .src_ready_i(src_ready_o),
    .dma_acc_o(dma_acc_i), .src_beat_o(src_beat_i));

  always @(posedge sys_clk_i) begin
    if (dst_o.valid && dst_o.is_crc) begin
      cap_d <= dst_o.data;
      cap_a <= dst_o.addr;
    end
  end

  function automatic logic [31:0] reo(input logic [31:0] x, input logic [1:0] b);
    case (b)
      2'h1: reo = {x[7:0], x[15:8], x[23:16], x[31:24]};
      2'h2: reo = {x[15:0], x[31:16]};
      2'h3: reo = {x[23:16], x[31:24], x[7:0], x[15:8]};
      default: reo = x;
    endcase
  endfunction

  function automatic logic [15:0] oc(input logic [15:0] a, input logic [15:0] c);
    logic [16:0] s;
    s = a + c;
    oc = s[15:0] + s[16];
  endfunction

  function automatic logic [31:0] view();
    view = ctl[5] ? {16'h0000, ~m_ip} : m_crc & (32'hFFFFFFFF >> (5'h1F - ctl[12:8]));
  endfunction

  // reference fold of one source word
  function automatic void fold(input logic [31:0] w);
    logic [31:0] x;
    logic [15:0] h, l;
    x = reo(w, ctl[29:28]);
    h = x[31:16];
    l = x[15:0];
    if (ctl[5]) begin
      if (ctl[24]) for (int i = 0; i < 16; i++) begin
        h[i] = x[31-i];
        l[i] = x[15-i];
      end
      m_ip = oc(oc(m_ip, h), l);
    end else begin
      for (int i = 0; i < 32; i++)
        m_crc = ((m_crc << 1) ^ (tap & {32{m_crc[ctl[12:8]] ^ (ctl[24] ? x[i] : x[31-i])}}))
                & (32'hFFFFFFFF >> (5'h1F - ctl[12:8]));
    end
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= ~w;
    avs_writedata_i <= wd;
    avs_byteenable_i <= be;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000, 4'hF);
    check(q, e);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #500000;
    n_mismatch++;
    print_verdict();
  end

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    for (int a = 0; a < 24; a += 4) rd(a[7:0], 32'h00000000);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      dcrc_dma_model_inst.access(d[0], i[2:0], d);
      bus(1'b1, `DCRC_OFS_STATUS, 32'hFFFFFFFF, 4'hF);
      rd(`DCRC_OFS_STATUS, {28'h0000000, d[0], i[2:0]});
      rd(`DCRC_OFS_LASTADDR, d);
    end
    $display("test bus status done");
    bus(1'b1, `DCRC_OFS_CTRL, 32'hFFFFFFFF, 4'hF);
    rd(`DCRC_OFS_CTRL, 32'h39001FA7);
    bus(1'b1, `DCRC_OFS_CTRL, 32'h00000040, 4'h1);
    rd(`DCRC_OFS_CTRL, 32'h39001F00);
    bus(1'b1, `DCRC_OFS_CTRL, 32'h000000C0, 4'hF);
    rd(`DCRC_OFS_CTRL, 32'h000000C0);
    $display("test control done");
    for (int i = 0; i < 16; i++) begin
      tap = $random(seed);
      sd = $random(seed);
      d = $random(seed);
      ctl = {2'h0, i[1:0], d[0], 2'h0, i[2], 11'h000, d[12:8], 1'b1, 1'b0, i[3], 2'h0, d[18:16]};
      bus(1'b1, `DCRC_OFS_TAP, tap, 4'hF);
      bus(1'b1, `DCRC_OFS_CTRL, ctl, 4'hF);
      bus(1'b1, `DCRC_OFS_SEED, sd, 4'hF);
      m_crc = sd;
      m_ip = ~sd[15:0];
      for (int k = 0; k < 3; k++) begin
        d = $random(seed);
        dcrc_dma_model_inst.beat(ctl[2:0] + {2'b00, k == 1}, 1'b0, d, 32'h00000000, k < 2);
        if (k != 1) fold(d);
      end
      rd(`DCRC_OFS_SEED, view());
    end
    ctl = ctl & 32'hFFFFFF7F;
    bus(1'b1, `DCRC_OFS_CTRL, ctl, 4'hF);
    dcrc_dma_model_inst.beat(ctl[2:0], 1'b0, d, 32'h00000000, 1'b0);
    rd(`DCRC_OFS_SEED, view());
    $display("test crc modes done");
    ctl = 32'h00001FC3;
    bus(1'b1, `DCRC_OFS_CTRL, ctl, 4'hF);
    bus(1'b1, `DCRC_OFS_SEED, sd, 4'hF);
    m_crc = sd;
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      dcrc_dma_model_inst.beat(3'h3, k == 3, d, tap, k < 3);
      fold(d);
    end
    repeat (4) @(posedge sys_clk_i);
    check(cap_d, view());
    check(cap_a, tap);
    $display("test append done");
    print_verdict();
  end
endmodule

bind dcrc_top dcrc_top_chk dcrc_top_chk_inst (.*);
